// file: design/siq_pkg.sv
// constants, field layout and enumerations of the inquiry response generator
//
// Behaviour
// RQ1 - standard byte 1: removable flag set, modifier zero
// RQ2 - byte 2: iso and ecma zero, ansi two
// RQ3 - byte 3: capability bits zero, format two
// RQ4 - byte 4 additional length 65h
// RQ5 - byte 7: only synchronous transfer bit set
// RQ6 - bytes 8-15 vendor name plus space
// RQ7 - bytes 16-31 product name, space, configuration id
// RQ8 - bytes 32-35 four character firmware revision
// RQ9 - bytes 36-55 blanks by default, customisable
// RQ10 - bytes 5, 6 and 56-95 carry nothing
// RQ11 - bytes 96-105 serial, blank padded at end
// RQ12 - supported pages byte 0: qualifier 0, type 01h
// RQ13 - supported pages: code 00h, length 02h
// RQ14 - supported pages list 00h then 80h
// RQ15 - serial page byte 0: 01h, 7Fh if lun nonzero
// RQ16 - serial page: code 80h, length 0Ah
// RQ17 - serial page bytes 4-13 serial, blank padded
// RQ18 - standard byte 0: 01h, 7Fh if lun nonzero
// RQ19 - select bit and page code choose response
// RQ20 - send lesser of allocation and response size
// RQ21 - reserved bits and bytes driven zero
// RQ22 - identity strings loaded into store at reset
package siq_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] SIQ_CTRL_OFS = 12'h000; // command register
  localparam logic [11:0] SIQ_STAT_OFS = 12'h004; // status register
  localparam logic [11:0] SIQ_SLEN_OFS = 12'h008; // serial length register
  localparam logic [11:0] SIQ_ID_OFS = 12'h100; // identity store window
  localparam int SIQ_ID_BYTES = 58; // store size in bytes
  localparam int SIQ_ID_SER = 48; // first serial byte in store

  // ****************************************
  // field positions
  // ****************************************
  localparam int SIQ_C_START = 0; // start bit
  localparam int SIQ_C_PRODUCT_DATA_SELECT = 1; // product data select bit
  localparam int SIQ_C_PAGE = 8; // page code low bit
  localparam int SIQ_C_LUN = 16; // lun low bit
  localparam int SIQ_C_ALLOC = 24; // allocation length low bit
  localparam int SIQ_S_BUSY = 0; // busy bit
  localparam int SIQ_S_DONE = 1; // done bit
  localparam int SIQ_S_BAD = 2; // bad selection bit
  localparam int SIQ_S_CNT = 8; // byte count low bit

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] SIQ_PAGE_RST = 8'h00; // page code after reset
  localparam logic [7:0] SIQ_ALLOC_RST = 8'h00; // allocation after reset
  localparam logic [3:0] SIQ_SLEN_RST = 4'hA; // serial length after reset

  // ****************************************
  // response sizes and fixed bytes
  // ****************************************
  localparam logic [6:0] SIQ_STD_LEN = 7'h6A; // standard data size
  localparam logic [6:0] SIQ_SUP_LEN = 7'h06; // supported pages size
  localparam logic [6:0] SIQ_SER_LEN = 7'h0E; // serial page size
  localparam logic [7:0] SIQ_DEV_SEQ = 8'h01; // sequential access type
  localparam logic [7:0] SIQ_LUN_BAD = 8'h7F; // invalid unit code
  localparam logic [7:0] SIQ_RMB_BYTE = 8'h80; // removable, modifier zero
  localparam logic [7:0] SIQ_VER_BYTE = 8'h02; // ansi version two
  localparam logic [7:0] SIQ_FMT_BYTE = 8'h02; // response format two
  localparam logic [7:0] SIQ_ADD_LEN = 8'h65; // additional length
  localparam logic [7:0] SIQ_CAP_BYTE = 8'h10; // synchronous only
  localparam logic [7:0] SIQ_PG_SUP = 8'h00; // supported pages code
  localparam logic [7:0] SIQ_PG_SER = 8'h80; // serial page code
  localparam logic [7:0] SIQ_SUP_PLEN = 8'h02; // supported page length
  localparam logic [7:0] SIQ_SER_PLEN = 8'h0A; // serial page length
  localparam logic [7:0] SIQ_BLANK = 8'h20; // ascii space
  localparam logic [7:0] SIQ_ZERO = 8'h00; // reserved content
  localparam logic [1:0] SIQ_OKAY = 2'h0; // axi okay
  localparam logic [1:0] SIQ_SLVERR = 2'h2; // axi slave error

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {SIQ_R_STD, SIQ_R_SUP, SIQ_R_SER} siq_resp_t;
  typedef enum logic {SIQ_IDLE, SIQ_SEND} siq_state_t;

endpackage

// file: design/siq_inquiry.sv
// inquiry response generator with axi4-lite control and byte stream out
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module siq_inquiry #(
  parameter logic [63:0] VENDOR_ID = 64'h56454E444F525820, // arbitrary value
  parameter logic [127:0] PRODUCT_ID = 128'h505244542D303030_2043464730303030, // arbitrary
  parameter logic [31:0] REVISION = 32'h30303030, // arbitrary value
  parameter logic [159:0] VENDOR_SPEC = {20{8'h20}}, // blanks by default
  parameter logic [79:0] SERIAL = 80'h30303030303030303030, // arbitrary value
  parameter logic [3:0] SERIAL_LEN = siq_pkg::SIQ_SLEN_RST // used serial chars
) (
  input wire logic aclk, // 100 mhz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic out_valid, // inquiry byte valid
  input wire logic out_ready, // initiator takes byte
  output logic [7:0] out_data, // inquiry byte
  output logic out_last // final byte of transfer
);

  // ****************************************
  // declarations
  // ****************************************
  // reset image of the text fields, vendor name first
  localparam logic [383:0] ID_IMG = {VENDOR_ID, PRODUCT_ID, REVISION, VENDOR_SPEC};
  logic [7:0] id_mem [siq_pkg::SIQ_ID_BYTES]; // identity store
  logic [3:0] ser_len; // serial characters in use
  logic product_data_select; // product data select
  logic [7:0] page; // requested page code
  logic [2:0] lun; // addressed unit
  logic [7:0] alloc; // allocation length
  logic start_req; // start pulse from bus
  logic done; // sticky transfer complete
  logic bad_sel; // unsupported selection seen
  siq_pkg::siq_state_t state; // transfer state
  siq_pkg::siq_resp_t cur_sel; // latched response kind
  logic cur_lun_bad; // latched invalid unit
  logic [6:0] idx; // index of byte on output
  logic [6:0] len; // bytes to send
  logic [6:0] sent; // bytes taken so far
  siq_pkg::siq_resp_t sel; // decoded response kind
  logic sel_ok; // selection is supported
  logic [6:0] full; // size of decoded response
  logic [6:0] xfer_len; // clipped length
  logic [6:0] nidx; // index being loaded
  siq_pkg::siq_resp_t f_sel; // kind being fetched
  logic f_lun_bad; // unit check being fetched
  logic [7:0] byte_nx; // byte being fetched
  logic take; // handshake on the stream
  logic aw_held; // write address captured
  logic w_held; // write data captured
  logic [11:0] aw_addr; // captured write address
  logic [31:0] w_data; // captured write data
  logic [3:0] w_strb; // captured byte enables
  logic wr_go; // perform the write
  logic [31:0] rd_word; // decoded read data
  logic rd_hit; // read address mapped
  logic wr_hit; // write address mapped

  // ****************************************
  // helpers
  // ****************************************
  // serial byte j with blank fill past the loaded length
  function automatic logic [7:0] ser_byte(input logic [6:0] j);
    logic [7:0] b;
    b = siq_pkg::SIQ_BLANK;
    if (j < {3'h0, ser_len}) begin
      b = id_mem[siq_pkg::SIQ_ID_SER + int'(j)];
    end
    return b;
  endfunction

  // identity window decode, shared by read and write
  function automatic logic id_hit(input logic [11:0] a);
    return (a >= siq_pkg::SIQ_ID_OFS) &&
           (a < siq_pkg::SIQ_ID_OFS + 12'(4 * siq_pkg::SIQ_ID_BYTES));
  endfunction

  // word index inside the identity window
  function automatic int id_idx(input logic [11:0] a);
    return int'((a - siq_pkg::SIQ_ID_OFS) >> 2);
  endfunction

  // ****************************************
  // axi write channel
  // ****************************************
  // address and data accepted independently, held until both are here
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (aw_addr == siq_pkg::SIQ_CTRL_OFS) ||
                  (aw_addr == siq_pkg::SIQ_STAT_OFS) ||
                  (aw_addr == siq_pkg::SIQ_SLEN_OFS) || id_hit(aw_addr);

  // capture of address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, unmapped addresses answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= siq_pkg::SIQ_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? siq_pkg::SIQ_OKAY : siq_pkg::SIQ_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // command register
  // ****************************************
  // fields may change while busy; the transfer latched its own copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      product_data_select <= 1'b0;
      page <= siq_pkg::SIQ_PAGE_RST;
      lun <= 3'h0;
      alloc <= siq_pkg::SIQ_ALLOC_RST;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (wr_go && aw_addr == siq_pkg::SIQ_CTRL_OFS) begin
        if (w_strb[0]) begin
          product_data_select <= w_data[siq_pkg::SIQ_C_PRODUCT_DATA_SELECT];
          // a start while busy is dropped, not queued
          start_req <= w_data[siq_pkg::SIQ_C_START] && state == siq_pkg::SIQ_IDLE;
        end
        if (w_strb[1]) begin
          page <= w_data[siq_pkg::SIQ_C_PAGE +: 8];
        end
        if (w_strb[2]) begin
          lun <= w_data[siq_pkg::SIQ_C_LUN +: 3];
        end
        if (w_strb[3]) begin
          alloc <= w_data[siq_pkg::SIQ_C_ALLOC +: 8];
        end
      end
    end
  end

  // ****************************************
  // identity store
  // ****************************************
  // strings come up from the parameter image at reset, software may patch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < siq_pkg::SIQ_ID_SER; i++) begin
        id_mem[i] <= ID_IMG[383 - 8 * i -: 8]; // RQ22
      end
      for (int j = 0; j < 10; j++) begin
        id_mem[siq_pkg::SIQ_ID_SER + j] <= SERIAL[79 - 8 * j -: 8]; // RQ22
      end
      ser_len <= SERIAL_LEN;
    end else if (wr_go && w_strb[0]) begin
      if (id_hit(aw_addr)) begin
        id_mem[id_idx(aw_addr)] <= w_data[7:0]; // RQ9
      end
      if (aw_addr == siq_pkg::SIQ_SLEN_OFS) begin
        // lengths above ten clip so padding stays inside the field
        ser_len <= (w_data[3:0] > 4'hA) ? 4'hA : w_data[3:0];
      end
    end
  end

  // ****************************************
  // response selection
  // ****************************************
  // select bit and page code pick one of three responses
  always_comb begin
    sel = siq_pkg::SIQ_R_STD;
    sel_ok = 1'b1;
    full = siq_pkg::SIQ_STD_LEN;
    if (!product_data_select) begin
      sel_ok = (page == siq_pkg::SIQ_PG_SUP); // RQ19
    end else if (page == siq_pkg::SIQ_PG_SUP) begin
      sel = siq_pkg::SIQ_R_SUP; // RQ19
      full = siq_pkg::SIQ_SUP_LEN;
    end else if (page == siq_pkg::SIQ_PG_SER) begin
      sel = siq_pkg::SIQ_R_SER; // RQ19
      full = siq_pkg::SIQ_SER_LEN;
    end else begin
      sel_ok = 1'b0;
    end
    // lesser of allocation and response size
    xfer_len = (alloc < {1'b0, full}) ? alloc[6:0] : full; // RQ20
  end

  // ****************************************
  // byte generator
  // ****************************************
  assign take = out_valid && out_ready;
  assign nidx = (state == siq_pkg::SIQ_IDLE) ? 7'h00 : 7'(idx + 7'h01);
  assign f_sel = (state == siq_pkg::SIQ_IDLE) ? sel : cur_sel;
  assign f_lun_bad = (state == siq_pkg::SIQ_IDLE) ? (lun != 3'h0) : cur_lun_bad;

  // content of the byte at nidx; anything unlisted reads zero
  always_comb begin
    byte_nx = siq_pkg::SIQ_ZERO; // RQ21
    case (f_sel)
      siq_pkg::SIQ_R_STD: begin
        if (nidx == 7'h00) begin
          byte_nx = f_lun_bad ? siq_pkg::SIQ_LUN_BAD : siq_pkg::SIQ_DEV_SEQ; // RQ18
        end else if (nidx == 7'h01) begin
          byte_nx = siq_pkg::SIQ_RMB_BYTE; // RQ1
        end else if (nidx == 7'h02) begin
          byte_nx = siq_pkg::SIQ_VER_BYTE; // RQ2
        end else if (nidx == 7'h03) begin
          byte_nx = siq_pkg::SIQ_FMT_BYTE; // RQ3
        end else if (nidx == 7'h04) begin
          byte_nx = siq_pkg::SIQ_ADD_LEN; // RQ4
        end else if (nidx == 7'h07) begin
          byte_nx = siq_pkg::SIQ_CAP_BYTE; // RQ5
        end else if (nidx >= 7'h08 && nidx < 7'h38) begin
          // vendor, product, revision, vendor specific in one run
          byte_nx = id_mem[int'(nidx) - 8]; // RQ6 RQ7 RQ8 RQ9
        end else if (nidx >= 7'h60) begin
          byte_nx = ser_byte(7'(nidx - 7'h60)); // RQ11
        end else begin
          byte_nx = siq_pkg::SIQ_ZERO; // RQ10
        end
      end
      siq_pkg::SIQ_R_SUP: begin
        case (nidx)
          7'h00: byte_nx = siq_pkg::SIQ_DEV_SEQ; // RQ12
          7'h01: byte_nx = siq_pkg::SIQ_PG_SUP; // RQ13
          7'h03: byte_nx = siq_pkg::SIQ_SUP_PLEN; // RQ13
          7'h04: byte_nx = siq_pkg::SIQ_PG_SUP; // RQ14
          7'h05: byte_nx = siq_pkg::SIQ_PG_SER; // RQ14
          default: byte_nx = siq_pkg::SIQ_ZERO; // RQ21
        endcase
      end
      siq_pkg::SIQ_R_SER: begin
        if (nidx == 7'h00) begin
          byte_nx = f_lun_bad ? siq_pkg::SIQ_LUN_BAD : siq_pkg::SIQ_DEV_SEQ; // RQ15
        end else if (nidx == 7'h01) begin
          byte_nx = siq_pkg::SIQ_PG_SER; // RQ16
        end else if (nidx == 7'h03) begin
          byte_nx = siq_pkg::SIQ_SER_PLEN; // RQ16
        end else if (nidx >= 7'h04) begin
          byte_nx = ser_byte(7'(nidx - 7'h04)); // RQ17
        end
      end
      default: byte_nx = siq_pkg::SIQ_ZERO;
    endcase
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  assign out_valid = (state == siq_pkg::SIQ_SEND);

  // one byte on the stream at a time, next one fetched on each take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= siq_pkg::SIQ_IDLE;
      cur_sel <= siq_pkg::SIQ_R_STD;
      cur_lun_bad <= 1'b0;
      idx <= 7'h00;
      len <= 7'h00;
      out_data <= siq_pkg::SIQ_ZERO;
      out_last <= 1'b0;
    end else begin
      case (state)
        siq_pkg::SIQ_IDLE: begin
          // zero length or bad selection sends nothing
          if (start_req && sel_ok && xfer_len != 7'h00) begin
            state <= siq_pkg::SIQ_SEND; // RQ20
            cur_sel <= sel;
            cur_lun_bad <= (lun != 3'h0);
            idx <= 7'h00;
            len <= xfer_len;
            out_data <= byte_nx;
            out_last <= (xfer_len == 7'h01);
          end
        end
        siq_pkg::SIQ_SEND: begin
          if (take && out_last) begin
            state <= siq_pkg::SIQ_IDLE; // RQ20
            out_last <= 1'b0;
          end else if (take) begin
            idx <= nidx;
            out_data <= byte_nx;
            out_last <= (7'(nidx + 7'h01) == len); // RQ20
          end
        end
        default: state <= siq_pkg::SIQ_IDLE;
      endcase
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // a new start clears the flags; the ending event wins over it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      bad_sel <= 1'b0;
      sent <= 7'h00;
    end else begin
      if (start_req) begin
        done <= 1'b0;
        bad_sel <= !sel_ok;
        sent <= 7'h00;
      end
      if (start_req && (!sel_ok || xfer_len == 7'h00)) begin
        done <= 1'b1;
      end
      if (take) begin
        sent <= 7'(sent + 7'h01);
        done <= out_last;
      end
    end
  end

  // ****************************************
  // axi read channel
  // ****************************************
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr[11:2] == siq_pkg::SIQ_CTRL_OFS[11:2]) begin
      rd_word[siq_pkg::SIQ_C_PRODUCT_DATA_SELECT] = product_data_select;
      rd_word[siq_pkg::SIQ_C_PAGE +: 8] = page;
      rd_word[siq_pkg::SIQ_C_LUN +: 3] = lun;
      rd_word[siq_pkg::SIQ_C_ALLOC +: 8] = alloc;
    end else if (s_axi_araddr[11:2] == siq_pkg::SIQ_STAT_OFS[11:2]) begin
      rd_word[siq_pkg::SIQ_S_BUSY] = (state == siq_pkg::SIQ_SEND) || start_req;
      rd_word[siq_pkg::SIQ_S_DONE] = done;
      rd_word[siq_pkg::SIQ_S_BAD] = bad_sel;
      rd_word[siq_pkg::SIQ_S_CNT +: 7] = sent;
    end else if (s_axi_araddr[11:2] == siq_pkg::SIQ_SLEN_OFS[11:2]) begin
      rd_word[3:0] = ser_len;
    end else if (id_hit({s_axi_araddr[11:2], 2'b00})) begin
      rd_word[7:0] = id_mem[id_idx({s_axi_araddr[11:2], 2'b00})];
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // registered read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= siq_pkg::SIQ_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? siq_pkg::SIQ_OKAY : siq_pkg::SIQ_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: tb/siq_inquiry_sva.sv
// port assertions for the inquiry response generator
`timescale 1ns/100ps
module siq_inquiry_sva (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic out_valid, // byte offered
  input wire logic out_ready, // byte taken
  input wire logic [7:0] out_data, // byte
  input wire logic out_last // final byte
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // helper count
  // ****
  logic [7:0] nb; // bytes taken this transfer
  // cleared whenever idle so each transfer counts from zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !out_valid) begin
      nb <= 8'h00;
    end else if (out_ready) begin
      nb <= nb + 8'h01;
    end
  end
  sequence s_wait; out_valid && !out_ready; endsequence // byte stalled
  sequence s_final; out_valid && out_ready && out_last; endsequence // last byte taken
  // ****
  // properties
  // ****
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stayed after accept");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response stayed after accept");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_out_hold: assert property (s_wait |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled byte changed");
  a_last_end: assert property (s_final |=> !out_valid)
    else $error("stream ran past last byte");
  a_len_cap: assert property (out_valid |-> nb < 8'h6A)
    else $error("more bytes than the largest response");
endmodule

// file: tb/siq_initiator.sv
// initiator model that reads the inquiry byte stream
`timescale 1ns/100ps
module siq_initiator (
  input wire logic aclk, // clock
  input wire logic slow, // stall every other cycle
  input wire logic out_valid, // byte offered
  input wire logic [7:0] out_data, // byte
  input wire logic out_last, // final byte
  output logic out_ready // byte taken
);
  logic [7:0] got [$]; // bytes received
  int last_at = -1; // index of byte flagged last
  initial out_ready = 1'b0;
  // take on handshake; slow mode toggles ready to force stalls
  always @(posedge aclk) begin
    if (out_valid && out_ready) begin
      if (out_last) last_at = got.size();
      got.push_back(out_data);
    end
    out_ready <= slow ? !out_ready : 1'b1;
  end
endmodule

// file: tb/tb_scsi_inquiry_response_gen.sv
// self-checking testbench of the inquiry response generator
`timescale 1ns/100ps
module tb_scsi_inquiry_response_gen;
  // ****
  // identity image, all values arbitrary
  // ****
  localparam logic [63:0] VND = 64'h5444524956452020; // arbitrary
  localparam logic [127:0] PRD = 128'h545041504550524F445F5F5F5F313233; // arbitrary
  localparam logic [31:0] REV = 32'h31323334; // arbitrary
  localparam logic [79:0] SER = 80'h4142434445464748494A; // arbitrary
  localparam logic [463:0] IMG = {VND, PRD, REV, {20{8'h20}}, SER}; // store order
  localparam logic [7:0] HDR [8] = '{8'h01, 8'h80, 8'h02, 8'h02, 8'h65, 8'h00, 8'h00, 8'h10};
  localparam logic [31:0] CASES [9] = '{32'hFF000001, 32'h08030001, 32'hFF020003,
    32'h0E008003, 32'hFF000101, 32'hFF008103, 32'h00000001, 32'h6A000001, 32'h0D018003};
  logic aclk = 1'b0; // clock
  logic aresetn = 1'b0; // reset, low
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000; // addresses
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0; // requests
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1; // always ready for answers
  logic [31:0] s_axi_wdata = 32'h00000000; // write data
  logic [3:0] s_axi_wstrb = 4'hF; // all lanes
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // slave
  logic [1:0] s_axi_bresp, s_axi_rresp; // responses
  logic [31:0] s_axi_rdata; // read data
  logic out_valid, out_ready, out_last; // stream
  logic [7:0] out_data; // stream byte
  logic slow = 1'b0; // partner stalls
  int err_total = 0, cmp_count = 0; // tallies
  logic [7:0] idm [58]; // expected store
  int sl = 10; // serial chars used
  siq_inquiry #(.VENDOR_ID(VND), .PRODUCT_ID(PRD), .REVISION(REV), .SERIAL(SER)) uut (.*);
  siq_initiator ini (.*);
  initial forever #5 aclk = ~aclk;
  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // write: offer both channels, drop each when taken, wait for response
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    chk("rresp", er, s_axi_rresp);
  endtask
  function automatic logic [7:0] ser(int j);
    return j < sl ? idm[48 + j] : 8'h20;
  endfunction
  // expected byte i of the response chosen by command word c
  function automatic logic [7:0] eb(logic [31:0] c, int i);
    logic [7:0] dev;
    dev = c[18:16] != 3'h0 ? 8'h7F : 8'h01;
    if (c[1] && c[15:8] == 8'h00) return i == 0 ? 8'h01 : i == 3 ? 8'h02 : i == 5 ? 8'h80 : 8'h00;
    if (c[1]) return i == 0 ? dev : i == 1 ? 8'h80 : i == 3 ? 8'h0A : i > 3 ? ser(i - 4) : 8'h00;
    return i == 0 ? dev : i < 8 ? HDR[i] : i < 56 ? idm[i - 8] : i < 96 ? 8'h00 : ser(i - 96);
  endfunction
  // one command: start, poll till idle, then check status and every byte
  task automatic run(input logic [31:0] c, input bit s);
    int n, z;
    logic [31:0] st;
    slow <= s;
    ini.got.delete();
    ini.last_at = -1;
    z = !c[1] ? (c[15:8] == 8'h00 ? 106 : 0) : c[15:8] == 8'h00 ? 6 : c[15:8] == 8'h80 ? 14 : 0;
    n = z < c[31:24] ? z : c[31:24];
    wr(12'h000, c, 2'h0);
    do rd(12'h004, st, 2'h0); while (st[0] !== 1'b0);
    chk("status", {17'h00000, n[6:0], 5'h00, z == 0, 2'h2}, st);
    chk("count", n, ini.got.size());
    chk("last", n - 1, ini.last_at);
    for (int i = 0; i < n; i++) begin
      chk($sformatf("byte %0d", i), eb(c, i), ini.got[i]);
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] d;
    for (int k = 0; k < 58; k++) idm[k] = IMG[463 - 8 * k -: 8];
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h004, d, 2'h0);
    chk("status reset", 32'h00000000, d);
    rd(12'h008, d, 2'h0);
    chk("serlen reset", 32'h0000000A, d);
    rd(12'h00C, d, 2'h2);
    chk("unmapped data", 32'h00000000, d);
    wr(12'h00C, 32'hFFFFFFFF, 2'h2);
    wr(12'h004, 32'hFFFFFFFF, 2'h0);
    rd(12'h004, d, 2'h0);
    chk("status ro", 32'h00000000, d);
    rd(12'h1C0, d, 2'h0);
    chk("store serial", {24'h000000, idm[48]}, d);
    $display("register map test done");
    for (int t = 0; t < 9; t++) begin
      // shorter serial and a customised vendor specific field for the last cases
      if (t == 7) begin
        wr(12'h008, 32'h00000006, 2'h0);
        sl = 6;
        wr(12'h178, 32'h00000041, 2'h0);
        idm[30] = 8'h41;
        rd(12'h178, d, 2'h0);
        chk("store write", 32'h00000041, d);
      end
      run(CASES[t], t[0]);
      $display("inquiry case %0d done", t);
    end
    test_done();
  end
  // watchdog, far beyond the few hundred cycles the cases need
  initial begin
    repeat (30000) @(posedge aclk);
    err_total++;
    test_done();
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
endmodule
bind siq_inquiry siq_inquiry_sva chk_i (.*);
